/* rtl/eep_pkg.sv */
/*
 * Shared constants of the two-wire serial memory: register map, field
 * positions, reset values, protocol codes and the link state encoding.
 * Assumes a single AHB-Lite slave port and one sampled two-wire link.
 */
package eep_pkg;
    localparam logic [7:0]  CTRL_OFF    = 8'h00;
    localparam logic [7:0]  STAT_OFF    = 8'h04;
    localparam int          CTRL_EN_BIT = 0;
    localparam int          CTRL_BIG_BIT = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h3;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_WP_BIT = 1;
    localparam int          STAT_SEL_LSB = 2;
    localparam int          STAT_W      = 5;
    localparam logic [3:0]  DEV_CODE    = 4'hA;
    localparam int          MEM_AW      = 15;
    localparam logic [14:0] MASK_SMALL  = 15'h3FFF;
    localparam logic [14:0] MASK_BIG    = 15'h7FFF;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
    localparam int          PIN_SCL     = 0;
    localparam int          PIN_SDA     = 1;
    localparam int          PIN_WP      = 2;
    localparam int          PIN_SEL_LSB = 3;
    localparam int          PIN_W       = 6;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV  = 4'h1,
        ST_ADEV = 4'h2,
        ST_AHI  = 4'h3,
        ST_KHI  = 4'h4,
        ST_ALO  = 4'h5,
        ST_KLO  = 4'h6,
        ST_WDAT = 4'h7,
        ST_KW   = 4'h8,
        ST_RDAT = 4'h9,
        ST_RACK = 4'hA
    } eep_state_e;
endpackage

/* rtl/eep_mem.sv */
/*
 * Byte array of the serial memory: one write port, one read port whose
 * data come out of a register. Assumes all ports on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_mem
    import eep_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [MEM_AW-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [MEM_AW-1:0] raddr,
    output logic      [7:0]        rdata
);
    logic [7:0] arr [0:(1<<MEM_AW)-1];

    // no reset: contents are non-volatile in spirit, only writes change them
    always_ff @(posedge clk) begin
        if (we) begin
            arr[waddr] <= wdata;
        end
        rdata <= arr[raddr];
    end
endmodule
`default_nettype wire

/* rtl/eep_top.sv */
/*
 * Two-wire serial memory slave with an AHB-Lite control port.
 * The link logic runs on link_clk, which oversamples the serial pins;
 * the register side runs on hclk. Assumes an external pull-up on the
 * data line and that hclk and link_clk are unrelated.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_top
    import eep_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        link_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        select_strap_bit0,
    input  wire logic        select_strap_bit1,
    input  wire logic        select_strap_bit2,
    input  wire logic        write_protect
);
    import eep_pkg::*;

    // register side
    logic [1:0]       ctrl;
    logic [1:0]       next_ctrl;
    logic             wr_pend;
    logic             next_wr_pend;
    logic [7:0]       addr_q;
    logic [7:0]       next_addr_q;
    logic [31:0]      next_hrdata;
    logic [STAT_W-1:0] stat_l;
    logic [STAT_W-1:0] stat_m;
    logic [STAT_W-1:0] stat_h;
    logic             take;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel & hready & htrans[1];

    always_comb begin
        next_wr_pend = take & hwrite;
        next_addr_q  = take ? haddr[7:0] : addr_q;
        next_ctrl    = ctrl;
        if (wr_pend && addr_q == CTRL_OFF) begin
            next_ctrl = hwdata[1:0];
        end
        next_hrdata = hrdata;
        if (take && !hwrite) begin
            next_hrdata = 32'h0000_0000;
            if (haddr[7:0] == CTRL_OFF) begin
                next_hrdata[1:0] = next_ctrl;
            end else if (haddr[7:0] == STAT_OFF) begin
                next_hrdata[STAT_W-1:0] = stat_h;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl    <= CTRL_RST;
            wr_pend <= 1'b0;
            addr_q  <= 8'h00;
            hrdata  <= 32'h0000_0000;
            stat_m  <= '0;
            stat_h  <= '0;
        end else begin
            ctrl    <= next_ctrl;
            wr_pend <= next_wr_pend;
            addr_q  <= next_addr_q;
            hrdata  <= next_hrdata;
            stat_m  <= stat_l;
            stat_h  <= stat_m;
        end
    end

    // link side reset: asserted at once, released on link_clk
    logic lrst_a;
    logic lrst_n;
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_a <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_a <= 1'b1;
            lrst_n <= lrst_a;
        end
    end

    // control levels into the link domain
    logic [1:0] ctrl_m;
    logic [1:0] ctrl_l;
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            ctrl_m <= CTRL_RST;
            ctrl_l <= CTRL_RST;
        end else begin
            ctrl_m <= ctrl;
            ctrl_l <= ctrl_m;
        end
    end

    // pins: three flops, the filtered level moves once flops 2 and 3 agree
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] lvl;
    logic [PIN_W-1:0] lvl_d;
    assign pin_raw = {select_strap_bit2, select_strap_bit1,
                      select_strap_bit0, write_protect, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            // all flops reset low, so the state before the first sample
            // reads low on every pin
            always_ff @(posedge link_clk or negedge lrst_n) begin
                if (!lrst_n) begin
                    s1          <= 1'b0;
                    s2          <= 1'b0;
                    s3          <= 1'b0;
                    lvl[gi]     <= 1'b0;
                    lvl_d[gi]   <= 1'b0;
                end else begin
                    s1          <= pin_raw[gi];
                    s2          <= s1;
                    s3          <= s2;
                    lvl[gi]     <= (s2 == s3) ? s2 : lvl[gi];
                    lvl_d[gi]   <= lvl[gi];
                end
            end
        end
    endgenerate

    logic       scl_f;
    logic       sda_f;
    logic       wp_f;
    logic [2:0] strap;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [14:0] mask;

    assign scl_f    = lvl[PIN_SCL];
    assign sda_f    = lvl[PIN_SDA];
    assign wp_f     = lvl[PIN_WP];
    assign strap    = lvl[PIN_SEL_LSB+2:PIN_SEL_LSB];
    assign scl_rise = scl_f & ~lvl_d[PIN_SCL];
    assign scl_fall = ~scl_f & lvl_d[PIN_SCL];
    // data edges count as frame marks only while the clock stays high
    assign start_det = scl_f & lvl_d[PIN_SCL] & ~sda_f & lvl_d[PIN_SDA];
    assign stop_det  = scl_f & lvl_d[PIN_SCL] & sda_f & ~lvl_d[PIN_SDA];
    assign mask = ctrl_l[CTRL_BIG_BIT] ? MASK_BIG : MASK_SMALL;

    // link state machine
    eep_state_e state;
    eep_state_e next_state;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [7:0]  sh;
    logic [7:0]  next_sh;
    logic [14:0] ptr;
    logic [14:0] next_ptr;
    logic        oe;
    logic        next_oe;
    logic        we;
    logic        next_we;
    logic        more;
    logic        next_more;
    logic [7:0]  rdata;
    logic        recv;

    assign recv = (state == ST_DEV) || (state == ST_AHI) ||
                  (state == ST_ALO) || (state == ST_WDAT);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_sh    = sh;
        next_ptr   = ptr;
        next_oe    = oe;
        next_we    = 1'b0;
        next_more  = more;
        if (!ctrl_l[CTRL_EN_BIT] || stop_det) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end else if (start_det) begin
            next_state = ST_DEV;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (scl_rise) begin
            if (recv && cnt != BITS_BYTE) begin
                next_sh  = {sh[6:0], sda_f};
                next_cnt = cnt + 4'h1;
            end else if (state == ST_RACK) begin
                next_more = ~sda_f;
            end
        end else if (scl_fall) begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_DEV: begin
                    if (cnt == BITS_BYTE) begin
                        // a foreign select code leaves the line alone
                        if (sh[7:4] == DEV_CODE && sh[3:1] == strap) begin
                            next_state = ST_ADEV;
                            next_oe    = 1'b1;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_AHI: begin
                    if (cnt == BITS_BYTE) begin
                        next_state = ST_KHI;
                        next_oe    = 1'b1;
                        next_ptr   = {sh[6:0], ptr[7:0]} & mask;
                    end
                end
                ST_ALO: begin
                    if (cnt == BITS_BYTE) begin
                        next_state = ST_KLO;
                        next_oe    = 1'b1;
                        next_ptr   = {ptr[14:8], sh} & mask;
                    end
                end
                ST_WDAT: begin
                    if (cnt == BITS_BYTE) begin
                        // protected bytes are refused and not acknowledged
                        next_state = ST_KW;
                        next_oe    = ~wp_f;
                        next_we    = ~wp_f;
                    end
                end
                ST_ADEV, ST_RACK: begin
                    next_cnt = 4'h0;
                    next_oe  = 1'b0;
                    if ((state == ST_ADEV && sh[0]) ||
                        (state == ST_RACK && more)) begin
                        next_state = ST_RDAT;
                        next_oe    = ~rdata[7];
                        next_sh    = {rdata[6:0], 1'b0};
                        next_cnt   = 4'h1;
                    end else if (state == ST_ADEV) begin
                        next_state = ST_AHI;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                ST_KHI, ST_KLO, ST_KW: begin
                    next_cnt   = 4'h0;
                    next_oe    = 1'b0;
                    next_state = (state == ST_KHI) ? ST_ALO : ST_WDAT;
                    if (state == ST_KW) begin
                        // whole-array wrap; no page boundary is kept
                        next_ptr = (ptr + 15'h0001) & mask;
                    end
                end
                ST_RDAT: begin
                    if (cnt == BITS_BYTE) begin
                        next_state = ST_RACK;
                        next_oe    = 1'b0;
                        next_more  = 1'b0;
                        next_ptr   = (ptr + 15'h0001) & mask;
                    end else begin
                        next_oe  = ~sh[7];
                        next_sh  = {sh[6:0], 1'b0};
                        next_cnt = cnt + 4'h1;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
            sh    <= 8'h00;
            ptr   <= 15'h0000;
            oe    <= 1'b0;
            we    <= 1'b0;
            more  <= 1'b0;
            stat_l <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            sh    <= next_sh;
            ptr   <= next_ptr;
            oe    <= next_oe;
            we    <= next_we;
            more  <= next_more;
            stat_l <= {strap, wp_f, (state != ST_IDLE)};
        end
    end

    // only a low is ever driven; the pull-up makes the high
    assign sda_o  = 1'b0;
    assign sda_oe = oe;

    eep_mem u_mem (
        .clk   (link_clk),
        .we    (we),
        .waddr (ptr),
        .wdata (sh),
        .raddr (ptr),
        .rdata (rdata)
    );

    sequence s_byte_in_done;
        state == ST_WDAT && scl_fall && cnt == BITS_BYTE &&
            !start_det && !stop_det && ctrl_l[CTRL_EN_BIT];
    endsequence

    chk_sel_match: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        state == ST_ADEV |-> sh[7:4] == DEV_CODE && sh[3:1] == strap)
        else $error("acknowledged a foreign select code");

    chk_foreign_nack: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        state == ST_DEV && scl_fall && cnt == BITS_BYTE &&
            sh[3:1] != strap && !start_det && !stop_det
        |=> state == ST_IDLE && !sda_oe)
        else $error("mismatched select was not ignored");

    chk_rise_sample: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        recv && $changed(cnt) && cnt != 4'h0 |-> $past(scl_rise))
        else $error("input bit taken away from a rising clock edge");

    chk_oe_on_fall: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $changed(sda_oe) |->
            $past(scl_fall || start_det || stop_det ||
                  !ctrl_l[CTRL_EN_BIT]))
        else $error("data line changed off a falling clock edge");

    chk_drive_owner: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        sda_oe |-> state inside {ST_ADEV, ST_KHI, ST_KLO, ST_KW, ST_RDAT})
        else $error("data line pulled low outside ack or read data");

    chk_wp_block: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        s_byte_in_done ##0 wp_f |=> (!we && !sda_oe) [*2])
        else $error("write went ahead while protected");

    chk_wp_write: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        s_byte_in_done ##0 !wp_f |=> we && sda_oe ##1 !we)
        else $error("unprotected write was not carried out");

    chk_ptr_range: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ctrl_l[CTRL_BIG_BIT] == 1'b0 && $stable(ctrl_l) |=> ptr[14] == 1'b0)
        else $error("pointer left the small array");

    chk_we_cause: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        we |-> $past(state) == ST_WDAT && $past(!wp_f))
        else $error("array written without an unprotected byte");
endmodule
`default_nettype wire

/* sim/eep_master_model.sv */
/*
 * Behavioural two-wire bus master: frames, bytes and master acks.
 * Assumes an open-drain data line resolved outside with a pull-up, and
 * that the caller starts each frame with the clock line high.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_master_model (
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // half period in link clocks; raised to play a slow master
    int   hp       = 16;
    logic unstable = 1'b0;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick();
        repeat (hp) @(posedge link_clk);
    endtask

    // data moves only while the clock is low, away from the falling edge
    task automatic bit_io(input logic b, output logic got);
        logic early;
        repeat (4) @(posedge link_clk);
        sda_low <= !b;
        tick();
        scl <= 1'b1;
        repeat (2) @(posedge link_clk);
        early = sda;
        tick();
        got = sda;
        if (early !== got)
            unstable = 1'b1;
        scl <= 1'b0;
    endtask

    // also serves as a repeated start after a byte
    task automatic start();
        repeat (4) @(posedge link_clk);
        sda_low <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
    endtask

    task automatic stop();
        repeat (4) @(posedge link_clk);
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask

    task automatic xfer(input logic [7:0] tx, input logic mack,
                        output logic [7:0] rx, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], g);
            rx[i] = g;
        end
        bit_io(mack, ack);
    endtask
endmodule
`default_nettype wire

/* sim/tb_serial_eeprom_pin_interface.sv */
/*
 * Self-checking bench: AHB-Lite register access plus serial frames
 * from the master model. Assumes one slave on the bus and a pull-up
 * on the shared data line.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_pin_interface;
    import eep_pkg::*;
    logic        hclk;
    logic        link_clk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [2:0]  straps;
    logic        wp;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sda_o;
    logic        sda_oe;
    logic        scl;
    logic        m_low;
    logic [7:0]  rx;
    logic        ak;
    logic [31:0] r;
    wire         sda_line;
    int          miscompares = 0;
    int          n_tests     = 0;

    assign sda_line = !(sda_oe || m_low);

    eep_top u_eep_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .select_strap_bit0(straps[0]), .select_strap_bit1(straps[1]),
        .select_strap_bit2(straps[2]), .write_protect(wp)
    );

    eep_master_model u_eep_master_model (
        .link_clk(link_clk), .sda(sda_line), .scl(scl), .sda_low(m_low)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
    endtask

    // entered just after a rising edge; leaves on the data-phase edge
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e,
                      input string what);
        ahb(1'b0, a, 32'h0);
        chk(r, e, what);
        chk(hresp, 1'b0, "bus response");
    endtask

    task automatic stp();
        u_eep_master_model.stop();
        @(posedge hclk);
    endtask

    task automatic sel(input logic [2:0] s, input logic rw,
                       input logic e_ack);
        u_eep_master_model.start();
        u_eep_master_model.xfer({DEV_CODE, s, rw}, 1'b1, rx, ak);
        chk(ak, e_ack, "device byte ack");
    endtask

    task automatic addr_ph(input logic [15:0] a);
        sel(straps, 1'b0, 1'b0);
        u_eep_master_model.xfer(a[15:8], 1'b1, rx, ak);
        chk(ak, 1'b0, "address high ack");
        u_eep_master_model.xfer(a[7:0], 1'b1, rx, ak);
        chk(ak, 1'b0, "address low ack");
    endtask

    task automatic ee_wr(input logic [15:0] a, input logic [7:0] d,
                         input int n, input logic e_ack);
        addr_ph(a);
        for (int i = 0; i < n; i++) begin
            u_eep_master_model.xfer(d + 8'(i), 1'b1, rx, ak);
            chk(ak, e_ack, "data byte ack");
        end
        stp();
    endtask

    task automatic ee_rd(input logic [15:0] a, input logic [7:0] e0,
                         input logic [7:0] e1, input int n);
        addr_ph(a);
        sel(straps, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_eep_master_model.xfer(8'hFF, i == n - 1, rx, ak);
            chk(rx, (i == 0) ? e0 : e1, "read byte");
        end
        stp();
    endtask

    initial begin
        #300000;
        miscompares++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        straps  = 3'h0;
        wp      = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        rd(CTRL_OFF, 32'h3, "control reset value");
        rd(STAT_OFF, 32'h0, "status reset value");
        ahb(1'b1, 32'h8, 32'hFFFFFFFF);
        rd(32'h8, 32'h0, "unmapped read");
        ahb(1'b1, CTRL_OFF, 32'h0);
        rd(CTRL_OFF, 32'h0, "control back to back");
        sel(3'h0, 1'b0, 1'b1);
        stp();
        ahb(1'b1, CTRL_OFF, 32'h3);
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            straps <= 3'(s);
            wp     <= s[0];
            repeat (20) @(posedge hclk);
            rd(STAT_OFF, {27'h0, 3'(s), s[0], 1'b0}, "pin status");
            sel(3'(s), 1'b0, 1'b0);
            stp();
            sel(3'(s) ^ 3'h5, 1'b0, 1'b1);
            stp();
        end
        wp <= 1'b0;
        $display("test addressing done");
        ee_wr(16'h0123, 8'h5A, 1, 1'b0);
        ee_rd(16'h0123, 8'h5A, 8'h00, 1);
        wp <= 1'b1;
        ee_wr(16'h0123, 8'hC3, 1, 1'b1);
        ee_rd(16'h0123, 8'h5A, 8'h00, 1);
        wp <= 1'b0;
        $display("test protection done");
        ee_wr(16'h7FFF, 8'hA0, 2, 1'b0);
        ahb(1'b1, CTRL_OFF, 32'h1);
        ee_wr(16'hFFFF, 8'hB0, 2, 1'b0);
        ee_rd(16'h3FFF, 8'hB0, 8'hB1, 2);
        ahb(1'b1, CTRL_OFF, 32'h3);
        u_eep_master_model.hp = 40;
        ee_rd(16'h7FFF, 8'hA0, 8'hB1, 2);
        chk(u_eep_master_model.unstable, 1'b0, "data held high");
        chk(sda_o, 1'b0, "driven level");
        $display("test array size done");
        final_report();
    end
endmodule
`default_nettype wire
